/* common/drf_pkg.sv */
// Types shared by the output routing block.
// Assumes nothing of its surroundings.
package drf_pkg;

	typedef logic signed [15:0] drf_sample_t;
	typedef logic signed [17:0] drf_wide_t;

	typedef struct packed {
		drf_sample_t chB;
		drf_sample_t chA;
	} drf_pair_t;

	typedef struct packed {
		drf_pair_t [1:0] mem;
		logic      [1:0] count;
		logic            valid;
		logic            ready;
	} drf_buf_state_t;

	typedef struct packed {
		logic [7:0]  routing;
		logic [7:0]  pulseFormat;
		logic        halfLsb;
		logic        dpEn;
		logic [3:0]  interp;
		logic        ducComplex;
		logic        ack;
		logic [31:0] rdData;
		logic [1:0]  clip;
		logic        mixSeen;
		logic        enA;
		logic        enB;
		logic [3:0]  ducMask;
	} drf_top_state_t;

endpackage

/* common/drf_regs.svh */
// Register offsets, field positions, reset values and codes of the output routing block.
// Assumes a 32-bit classic Wishbone slave with byte addresses, register index = address / 4.
`ifndef DRF_REGS_SVH
`define DRF_REGS_SVH

`define DRF_IDX_DP_ENABLE      10'h2E0
`define DRF_IDX_INTERP         10'h2E1
`define DRF_IDX_UPCONV_FORMAT  10'h2E3
`define DRF_IDX_ROUTING        10'h2E4
`define DRF_IDX_PULSE_FORMAT   10'h2E8
`define DRF_IDX_HALF_LSB       10'h2EA
`define DRF_IDX_STATUS         10'h2F0

`define DRF_ROUTE_CH1_MSB      7
`define DRF_ROUTE_CH1_LSB      4
`define DRF_ROUTE_CH0_MSB      3
`define DRF_ROUTE_CH0_LSB      0
`define DRF_FMT_B_MSB          6
`define DRF_FMT_B_LSB          4
`define DRF_FMT_A_MSB          2
`define DRF_FMT_A_LSB          0
`define DRF_FMT_WRITE_MASK     8'h77

`define DRF_RESET_BYTE         8'h00
`define DRF_RESET_INTERP       4'h0
`define DRF_INTERP_BYPASS_MAX  4'h1

`define DRF_PULSE_NRZ          3'h0
`define DRF_PULSE_RTI          3'h1
`define DRF_PULSE_RTZ          3'h2
`define DRF_PULSE_LOWPASS      3'h3
`define DRF_PULSE_HIGHPASS     3'h4
`define DRF_PULSE_DISABLED     3'h6

`define DRF_DUC_ALL            4'hF
`define DRF_DUC_COMPLEX        4'h3

`define DRF_SAMPLE_MAX         18'sh07FFF
`define DRF_SAMPLE_MIN         18'sh38000

`endif

/* common/drf_stream_if.sv */
// Valid/ready sample-pair stream between the router and its output buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface drf_stream_if;
	logic              valid;
	logic              ready;
	drf_pkg::drf_pair_t data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

/* core/drf_out_buffer.sv */
// Two-entry buffer for converter sample pairs, ready and valid from flip-flops.
// Assumes flush is synchronous to clk and held while the datapath is disabled.
`timescale 1ns/10ps
module drf_out_buffer (
	input wire logic    clk,
	input wire logic    rst,
	input wire logic    flush,
	drf_stream_if.snk   up,
	drf_stream_if.src   down
);
	drf_pkg::drf_buf_state_t st;
	drf_pkg::drf_buf_state_t next_st;
	logic                    push;
	logic                    pop;

	assign up.ready   = st.ready;
	assign down.valid = st.valid;
	assign down.data  = st.mem[0];

	always_comb begin
		next_st = st;
		push    = up.valid & st.ready;
		pop     = st.valid & down.ready;
		if (push && pop) begin
			if (st.count == 2'd2) begin
				next_st.mem[0] = st.mem[1];
				next_st.mem[1] = up.data;
			end else begin
				next_st.mem[0] = up.data;
			end
		end else if (pop) begin
			next_st.mem[0] = st.mem[1];
			next_st.count  = st.count - 2'd1;
		end else if (push) begin
			if (st.count == 2'd0) begin
				next_st.mem[0] = up.data;
			end else begin
				next_st.mem[1] = up.data;
			end
			next_st.count = st.count + 2'd1;
		end
		if (flush) begin
			next_st.count = 2'd0;
			next_st.mem   = '0;
		end
		next_st.valid = (next_st.count != 2'd0);
		next_st.ready = (next_st.count != 2'd2) & ~flush;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

/* core/drf_routing_top.sv */
// Converter source routing, summing and pulse format control with a Wishbone register slave.
// Assumes upstream streams and upconverter outputs are in the clk domain and share inValid.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/10ps
`include "drf_regs.svh"
module drf_routing_top (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    wbCyc,
	input  wire logic                    wbStb,
	input  wire logic                    wbWe,
	input  wire logic [11:0]             wbAdr,
	input  wire logic [3:0]              wbSel,
	input  wire logic [31:0]             wbDatI,
	output wire logic [31:0]             wbDatO,
	output wire logic                    wbAck,
	input  wire logic                    inValid,
	output wire logic                    inReady,
	input  wire drf_pkg::drf_sample_t    streamI,
	input  wire drf_pkg::drf_sample_t    streamQ,
	input  wire logic [3:0][15:0]        ducReal,
	input  wire logic [1:0][15:0]        ducImag,
	output wire logic                    outValid,
	input  wire logic                    outReady,
	output wire drf_pkg::drf_sample_t    converterASample,
	output wire drf_pkg::drf_sample_t    converterBSample,
	output wire logic [2:0]              converterAPulseFormat,
	output wire logic [2:0]              converterBPulseFormat,
	output wire logic                    converterAEnable,
	output wire logic                    converterBEnable,
	output wire logic                    halfLsbTruncationOffset,
	output wire logic                    datapathEnable,
	output wire logic [3:0]              upconverterEnableMask
);
	drf_pkg::drf_top_state_t st;
	drf_pkg::drf_top_state_t next_st;
	drf_stream_if            upIf ();
	drf_stream_if            downIf ();

	logic                    busHit;
	logic                    bypass;
	logic [3:0]              selA;
	logic [3:0]              selB;
	drf_pkg::drf_wide_t      sumA;
	drf_pkg::drf_wide_t      sumB;
	logic                    push;

	// Selected sources of one converter, summed at full width
	function automatic drf_pkg::drf_wide_t route_sum(
		input logic [3:0]       sel,
		input logic             byp,
		input logic             cplx,
		input logic [15:0]      sI,
		input logic [15:0]      sQ,
		input logic [3:0][15:0] re,
		input logic [1:0][15:0] im
	);
		drf_pkg::drf_wide_t acc;
		acc = '0;
		if (byp) begin
			if (sel[0]) begin
				acc = acc + drf_pkg::drf_wide_t'($signed(sI));
			end
			if (sel[1]) begin
				acc = acc + drf_pkg::drf_wide_t'($signed(sQ));
			end
		end else if (cplx) begin
			for (int k = 0; k < 2; k++) begin
				if (sel[k]) begin
					acc = acc + drf_pkg::drf_wide_t'($signed(re[k]));
				end
				if (sel[k + 2]) begin
					acc = acc + drf_pkg::drf_wide_t'($signed(im[k]));
				end
			end
		end else begin
			for (int k = 0; k < 4; k++) begin
				if (sel[k]) begin
					acc = acc + drf_pkg::drf_wide_t'($signed(re[k]));
				end
			end
		end
		return acc;
	endfunction

	// Saturate a wide sum to the converter word
	function automatic drf_pkg::drf_sample_t clip16(input drf_pkg::drf_wide_t v);
		if (v > `DRF_SAMPLE_MAX) begin
			return drf_pkg::drf_sample_t'(`DRF_SAMPLE_MAX);
		end else if (v < `DRF_SAMPLE_MIN) begin
			return drf_pkg::drf_sample_t'(`DRF_SAMPLE_MIN);
		end
		return v[15:0];
	endfunction

	function automatic logic overflows(input drf_pkg::drf_wide_t v);
		return (v > `DRF_SAMPLE_MAX) || (v < `DRF_SAMPLE_MIN);
	endfunction

	// Codes 5 and 7 also keep the converter off
	function automatic logic pulse_enabled(input logic [2:0] code);
		return code <= `DRF_PULSE_HIGHPASS;
	endfunction

	assign selA   = st.routing[`DRF_ROUTE_CH0_MSB:`DRF_ROUTE_CH0_LSB];
	assign selB   = st.routing[`DRF_ROUTE_CH1_MSB:`DRF_ROUTE_CH1_LSB];
	assign bypass = (st.interp <= `DRF_INTERP_BYPASS_MAX);
	assign sumA   = route_sum(selA, bypass, st.ducComplex, streamI, streamQ, ducReal, ducImag);
	assign sumB   = route_sum(selB, bypass, st.ducComplex, streamI, streamQ, ducReal, ducImag);

	assign upIf.valid       = inValid & st.dpEn;
	assign upIf.data        = {clip16(sumB), clip16(sumA)};
	assign push             = upIf.valid & upIf.ready;
	assign inReady          = upIf.ready;
	assign downIf.ready     = outReady;
	assign outValid         = downIf.valid;
	assign converterASample = downIf.data.chA;
	assign converterBSample = downIf.data.chB;

	drf_out_buffer u_buf (
		.clk   (clk),
		.rst   (rst),
		.flush (~next_st.dpEn),
		.up    (upIf),
		.down  (downIf)
	);

	assign wbDatO                  = st.rdData;
	assign wbAck                   = st.ack;
	assign converterAPulseFormat   = st.pulseFormat[`DRF_FMT_A_MSB:`DRF_FMT_A_LSB];
	assign converterBPulseFormat   = st.pulseFormat[`DRF_FMT_B_MSB:`DRF_FMT_B_LSB];
	assign converterAEnable        = st.enA;
	assign converterBEnable        = st.enB;
	assign halfLsbTruncationOffset = st.halfLsb;
	assign datapathEnable          = st.dpEn;
	assign upconverterEnableMask   = st.ducMask;

	always_comb begin
		next_st     = st;
		next_st.ack = 1'b0;
		busHit      = wbCyc & wbStb & ~st.ack;
		if (busHit) begin
			next_st.ack    = 1'b1;
			next_st.rdData = '0;
			case (wbAdr[11:2])
				`DRF_IDX_DP_ENABLE: begin
					next_st.rdData[0] = st.dpEn;
				end
				`DRF_IDX_INTERP: begin
					next_st.rdData[3:0] = st.interp;
				end
				`DRF_IDX_UPCONV_FORMAT: begin
					next_st.rdData[0] = st.ducComplex;
				end
				`DRF_IDX_ROUTING: begin
					next_st.rdData[7:0] = st.routing;
				end
				`DRF_IDX_PULSE_FORMAT: begin
					next_st.rdData[7:0] = st.pulseFormat;
				end
				`DRF_IDX_HALF_LSB: begin
					next_st.rdData[0] = st.halfLsb;
				end
				`DRF_IDX_STATUS: begin
					next_st.rdData[3:0] = {upIf.ready, st.mixSeen, st.clip};
				end
				default: begin
					next_st.rdData = '0;
				end
			endcase
			if (wbWe && wbSel[0]) begin
				case (wbAdr[11:2])
					`DRF_IDX_DP_ENABLE: begin
						next_st.dpEn = wbDatI[0];
					end
					`DRF_IDX_INTERP: begin
						next_st.interp = wbDatI[3:0];
					end
					`DRF_IDX_UPCONV_FORMAT: begin
						next_st.ducComplex = wbDatI[0];
					end
					`DRF_IDX_ROUTING: begin
						next_st.routing = wbDatI[7:0];
					end
					`DRF_IDX_PULSE_FORMAT: begin
						next_st.pulseFormat = wbDatI[7:0] & `DRF_FMT_WRITE_MASK;
					end
					`DRF_IDX_HALF_LSB: begin
						next_st.halfLsb = wbDatI[0];
					end
					`DRF_IDX_STATUS: begin
						next_st.clip    = st.clip & ~wbDatI[1:0];
						next_st.mixSeen = st.mixSeen & ~wbDatI[2];
					end
					default: begin
						next_st.dpEn = next_st.dpEn;
					end
				endcase
			end
		end
		// Sticky events; a set in the same cycle beats a write-one clear
		if (push) begin
			next_st.clip[0] = next_st.clip[0] | overflows(sumA);
			next_st.clip[1] = next_st.clip[1] | overflows(sumB);
		end
		if (st.dpEn && !bypass && st.ducComplex) begin
			if (((selA[1:0] != 2'b00) && (selA[3:2] != 2'b00)) ||
				((selB[1:0] != 2'b00) && (selB[3:2] != 2'b00))) begin
				next_st.mixSeen = 1'b1;
			end
		end
		if (!st.dpEn) begin
			next_st.clip    = 2'b00;
			next_st.mixSeen = 1'b0;
		end
		next_st.enA     = next_st.dpEn & pulse_enabled(next_st.pulseFormat[`DRF_FMT_A_MSB:`DRF_FMT_A_LSB]);
		next_st.enB     = next_st.dpEn & pulse_enabled(next_st.pulseFormat[`DRF_FMT_B_MSB:`DRF_FMT_B_LSB]);
		next_st.ducMask = next_st.ducComplex ? `DRF_DUC_COMPLEX : `DRF_DUC_ALL;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st         <= '0;
			st.ducMask <= `DRF_DUC_ALL;
		end else begin
			st <= next_st;
		end
	end
endmodule

/* verification/dac_output_routing_and_pulse_format_bench.sv */
// Self-checking bench: registers, routed sums, pulse formats, buffer stalls.
// Assumes design, sink model and checker are compiled first.
`timescale 1ns/10ps
`include "drf_regs.svh"
module dac_output_routing_and_pulse_format_bench;
	logic                 clk, rst, wbCyc, wbStb, wbWe, wbAck, inValid, inReady, outValid, outReady, stall, cplx;
	logic [11:0]          wbAdr;
	logic [3:0]           wbSel, interp, upconverterEnableMask;
	logic [31:0]          wbDatI, wbDatO, rd;
	drf_pkg::drf_sample_t streamI, streamQ, converterASample, converterBSample;
	logic [3:0][15:0]     ducReal;
	logic [1:0][15:0]     ducImag;
	logic [2:0]           converterAPulseFormat, converterBPulseFormat;
	logic                 converterAEnable, converterBEnable, halfLsbTruncationOffset, datapathEnable;
	logic [7:0]           route;
	logic [1:0]           clipSeen;
	logic [31:0]          q[$];
	int                   err_total, checks;
	logic [9:0]           regs [4] = '{`DRF_IDX_ROUTING, `DRF_IDX_PULSE_FORMAT, `DRF_IDX_HALF_LSB, 10'h3FF};
	// Legal routings only: one bypass source each, no real with imaginary
	logic [12:0]          cfg [6] = '{13'h0021, 13'h0212, 13'h04F5, 13'h060A, 13'h05C3, 13'h0B08};
	drf_routing_top i_dut (
		.clk                     (clk),
		.rst                     (rst),
		.wbCyc                   (wbCyc),
		.wbStb                   (wbStb),
		.wbWe                    (wbWe),
		.wbAdr                   (wbAdr),
		.wbSel                   (wbSel),
		.wbDatI                  (wbDatI),
		.wbDatO                  (wbDatO),
		.wbAck                   (wbAck),
		.inValid                 (inValid),
		.inReady                 (inReady),
		.streamI                 (streamI),
		.streamQ                 (streamQ),
		.ducReal                 (ducReal),
		.ducImag                 (ducImag),
		.outValid                (outValid),
		.outReady                (outReady),
		.converterASample        (converterASample),
		.converterBSample        (converterBSample),
		.converterAPulseFormat   (converterAPulseFormat),
		.converterBPulseFormat   (converterBPulseFormat),
		.converterAEnable        (converterAEnable),
		.converterBEnable        (converterBEnable),
		.halfLsbTruncationOffset (halfLsbTruncationOffset),
		.datapathEnable          (datapathEnable),
		.upconverterEnableMask   (upconverterEnableMask)
	);
	drf_sink_model i_sink (.clk(clk), .rst(rst), .stall(stall), .outReady(outReady));
	task automatic conclude();
		if (err_total == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= {idx, 2'h0};
		wbDatI <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (wbAck !== 1'b1 && n < 20);
		rd = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		if (n >= 20) begin
			err_total++;
			conclude();
		end
		@(posedge clk);
	endtask
	task automatic setup(input logic [12:0] c, input logic [7:0] f);
		{interp, cplx, route} = c;
		bus(1'b1, `DRF_IDX_DP_ENABLE, 8'h00);
		bus(1'b1, `DRF_IDX_INTERP, {4'h0, interp});
		bus(1'b1, `DRF_IDX_UPCONV_FORMAT, {7'h0, cplx});
		bus(1'b1, `DRF_IDX_ROUTING, route);
		bus(1'b1, `DRF_IDX_PULSE_FORMAT, f);
		bus(1'b1, `DRF_IDX_DP_ENABLE, 8'h01);
		repeat (3) @(posedge clk);
	endtask
	// Unclipped sum of the sources selected by s
	function automatic int rawsum(input logic [3:0] s);
		int acc;
		logic [15:0] v;
		acc = 0;
		for (int k = 0; k < 4; k++) begin
			v = interp <= 4'h1 ? (k == 0 ? streamI : k == 1 ? streamQ : 16'h0)
				: cplx && k > 1 ? ducImag[k-2] : ducReal[k];
			if (s[k])
				acc += int'($signed(v));
		end
		return acc;
	endfunction
	// Expected converter sample from the sources selected by s
	function automatic logic [15:0] mix(input logic [3:0] s);
		int acc;
		acc = rawsum(s);
		acc = acc > 32767 ? 32767 : acc < -32768 ? -32768 : acc;
		return acc[15:0];
	endfunction
	function automatic logic ovf(input logic [3:0] s);
		return rawsum(s) > 32767 || rawsum(s) < -32768;
	endfunction
	task automatic traffic(input int n);
		int t;
		repeat (n) begin
			inValid <= 1'($urandom);
			streamI <= 16'($urandom);
			streamQ <= 16'($urandom);
			ducReal <= {$urandom, $urandom};
			ducImag <= $urandom;
			@(posedge clk);
		end
		inValid <= 1'b0;
		for (t = 0; q.size() != 0 && t < 200; t++)
			@(posedge clk);
		if (t == 200) begin
			err_total++;
			conclude();
		end
	endtask
	always @(posedge clk) begin
		if (!rst && inValid && inReady) begin
			q.push_back({mix(route[7:4]), mix(route[3:0])});
			clipSeen = clipSeen | {ovf(route[7:4]), ovf(route[3:0])};
		end
		if (!rst && outValid && outReady)
			chk({converterBSample, converterASample}, q.pop_front());
	end
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		wbSel = 4'hF;
		{wbCyc, wbStb, wbWe, inValid, stall} = 5'h0;
		{wbAdr, wbDatI, streamI, streamQ, ducReal, ducImag} = '0;
		void'($urandom(32'h3C868511));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (regs[i]) begin
			bus(1'b0, regs[i], 8'h00);
			chk(rd, 32'h0);
		end
		bus(1'b1, `DRF_IDX_PULSE_FORMAT, 8'hFF);
		bus(1'b0, `DRF_IDX_PULSE_FORMAT, 8'h00);
		chk(rd, 32'h77);
		bus(1'b1, `DRF_IDX_ROUTING, 8'hA5);
		bus(1'b0, `DRF_IDX_ROUTING, 8'h00);
		chk(rd, 32'hA5);
		bus(1'b1, `DRF_IDX_HALF_LSB, 8'h01);
		bus(1'b0, `DRF_IDX_HALF_LSB, 8'h00);
		chk({rd[30:0], halfLsbTruncationOffset}, 32'h3);
		for (int c = 0; c < 8; c++) begin
			setup(13'h0011, {1'b1, 3'(7 - c), 1'b1, 3'(c)});
			chk({converterBPulseFormat, converterAPulseFormat, converterBEnable, converterAEnable},
				{3'(7 - c), 3'(c), 1'(7 - c <= 4), 1'(c <= 4)});
		end
		foreach (cfg[i]) begin
			setup(cfg[i], 8'h00);
			clipSeen = 2'b00;
			chk({datapathEnable, upconverterEnableMask}, {1'b1, cplx ? 4'h3 : 4'hF});
			traffic(60);
			// Status: ready, no mix, sticky clips; flags cleared by the disable in setup
			bus(1'b0, `DRF_IDX_STATUS, 8'h00);
			chk(rd, {28'h0, 2'b10, clipSeen});
			bus(1'b1, `DRF_IDX_STATUS, 8'h07);
			bus(1'b0, `DRF_IDX_STATUS, 8'h00);
			chk(rd, 32'h8);
		end
		// Fill the buffer until it refuses, then flush it by disabling
		stall <= 1'b1;
		inValid <= 1'b1;
		repeat (6) @(posedge clk);
		inValid <= 1'b0;
		chk({inReady, 30'(q.size())}, 32'h2);
		bus(1'b1, `DRF_IDX_DP_ENABLE, 8'h00);
		@(posedge clk);
		chk({inReady, outValid}, 32'h0);
		q.delete();
		conclude();
	end
endmodule

/* verification/drf_routing_assertions.sv */
// Checks on the top ports of the routing block.
// Assumes one clock domain; bound into the top module below.
`timescale 1ns/10ps
module drf_checker (
	input wire logic                 clk,
	input wire logic                 rst,
	input wire logic                 wbCyc,
	input wire logic                 wbStb,
	input wire logic                 wbWe,
	input wire logic [11:0]          wbAdr,
	input wire logic [31:0]          wbDatO,
	input wire logic                 wbAck,
	input wire logic                 inReady,
	input wire logic                 outValid,
	input wire logic                 outReady,
	input wire drf_pkg::drf_sample_t converterASample,
	input wire drf_pkg::drf_sample_t converterBSample,
	input wire logic [2:0]           converterAPulseFormat,
	input wire logic [2:0]           converterBPulseFormat,
	input wire logic                 converterAEnable,
	input wire logic                 converterBEnable,
	input wire logic                 datapathEnable,
	input wire logic [3:0]           upconverterEnableMask
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	AST_ACK_ONE: assert property (wbAck |=> !wbAck)
		else $error("ack too long");
	AST_ACK_REQ: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
		else $error("request unanswered");
	AST_FMT_RSV: assert property (wbAck && !wbWe && wbAdr[11:2] == 10'h2E8 |->
		wbDatO[31:8] == 24'h0 && !wbDatO[7] && !wbDatO[3])
		else $error("reserved bits set");
	AST_EN_A: assert property (converterAEnable |-> converterAPulseFormat <= 3'h4)
		else $error("converter A enabled");
	AST_EN_B: assert property (converterBEnable |-> converterBPulseFormat <= 3'h4)
		else $error("converter B enabled");
	AST_IDLE: assert property (!datapathEnable && !$past(datapathEnable) |-> !inReady && !outValid)
		else $error("path active while disabled");
	AST_MASK: assert property (upconverterEnableMask == 4'h3 || upconverterEnableMask == 4'hF)
		else $error("bad upconverter mask");
	AST_HOLD: assert property (outValid && !outReady && datapathEnable |=> !datapathEnable ||
		(outValid && $stable(converterASample) && $stable(converterBSample)))
		else $error("stalled sample changed");
	cover property (outValid && !outReady);
	cover property (!inReady && datapathEnable);
	cover property (converterBEnable && converterBPulseFormat == 3'h4);
endmodule
bind drf_routing_top drf_checker i_chk (
	.clk                   (clk),
	.rst                   (rst),
	.wbCyc                 (wbCyc),
	.wbStb                 (wbStb),
	.wbWe                  (wbWe),
	.wbAdr                 (wbAdr),
	.wbDatO                (wbDatO),
	.wbAck                 (wbAck),
	.inReady               (inReady),
	.outValid              (outValid),
	.outReady              (outReady),
	.converterASample      (converterASample),
	.converterBSample      (converterBSample),
	.converterAPulseFormat (converterAPulseFormat),
	.converterBPulseFormat (converterBPulseFormat),
	.converterAEnable      (converterAEnable),
	.converterBEnable      (converterBEnable),
	.datapathEnable        (datapathEnable),
	.upconverterEnableMask (upconverterEnableMask)
);

/* verification/drf_sink_model.sv */
// Receiver model for the converter sample stream.
// Assumes the bench raises stall to hold it back; otherwise it accepts at random.
`timescale 1ns/10ps
module drf_sink_model (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic stall,
	output logic      outReady
);
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			outReady <= 1'b0;
		else
			outReady <= !stall && ($urandom % 4 != 0);
	end
endmodule
